// *** hw/cirp_defines.svh ***
// Purpose: Offsets, field positions, reset values and indexes of the CAN register port.
// Assumes: One special-function page holds every window register.
// Notes:   Definitions only; included by bare name.
`ifndef CIRP_DEFINES_SVH
`define CIRP_DEFINES_SVH

// ----------------------------------------------------------------------
// Special-function addresses
// ----------------------------------------------------------------------
`define CIRP_PAGE          8'h01
`define CIRP_ADDR_LOW      8'hD8
`define CIRP_ADDR_HIGH     8'hD9
`define CIRP_ADDR_INDEX    8'hDA
`define CIRP_ADDR_TEST     8'hDB
`define CIRP_ADDR_CTRL     8'hF8
`define CIRP_ADDR_STAT     8'hC0

// ----------------------------------------------------------------------
// Controller register indexes
// ----------------------------------------------------------------------
`define CIRP_IDX_CTRL      8'h00
`define CIRP_IDX_STAT      8'h01
`define CIRP_IDX_TEST      8'h05
`define CIRP_IF1_FIRST     8'h08
`define CIRP_IF1_LAST      8'h12
`define CIRP_IF2_FIRST     8'h20
`define CIRP_IF2_LAST      8'h2A

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define CIRP_IRQ_BIT       4
`define CIRP_RST_WORD      16'h0001
`define CIRP_RST_HIGH      8'h00
`define CIRP_RST_INDEX     8'h00

`endif

// *** hw/cirp_index_ptr.sv ***
// Purpose: Index pointer with auto-increment over the message-interface ranges.
// Assumes: load and inc never arrive in the same cycle.
// Notes:   A load wins if both are seen.
`include "cirp_defines.svh"
`default_nettype none

module cirp_index_ptr
    import cirp_pkg::*;
(
    input  wire logic  clock,
    input  wire logic  reset,
    cirp_ptr_if.owner  bus
);

    cirp_ptr_t st_q;
    cirp_ptr_t st_d;
    logic      in_range;

    // ------------------------------------------------------------------
    // Pointer update
    // ------------------------------------------------------------------
    always_comb begin
        in_range = ((st_q.ptr >= `CIRP_IF1_FIRST) && (st_q.ptr <= `CIRP_IF1_LAST)) ||
                   ((st_q.ptr >= `CIRP_IF2_FIRST) && (st_q.ptr <= `CIRP_IF2_LAST));
        st_d = st_q;
        if (bus.load) begin
            st_d.ptr = bus.load_val;
        end else if (bus.inc && in_range) begin
            st_d.ptr = st_q.ptr + 8'h01;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_q <= '{ptr: `CIRP_RST_INDEX};
        end else begin
            st_q <= st_d;
        end
    end

    assign bus.ptr = st_q.ptr;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    AST_PTR_LOAD: assert property (
        bus.load |=> (bus.ptr == $past(bus.load_val))
    ) else $error("index pointer did not take the loaded value");

    AST_PTR_INC: assert property (
        (bus.inc && !bus.load && in_range) |=> (bus.ptr == $past(bus.ptr) + 8'h01)
    ) else $error("index pointer did not advance inside an interface range");

    AST_PTR_STILL: assert property (
        (bus.inc && !bus.load && !in_range) |=> $stable(bus.ptr)
    ) else $error("index pointer moved outside an interface range");

    AST_PTR_RESET: assert property (
        @(posedge clock) disable iff (1'b0)
        $fell(reset) |-> (bus.ptr == `CIRP_RST_INDEX)
    ) else $error("index pointer not cleared by reset");

endmodule

`default_nettype wire

// *** hw/cirp_pkg.sv ***
// Purpose: Types shared by the CAN register port modules.
// Assumes: Constants come from cirp_defines.svh.
// Notes:   Each module keeps all of its state in one packed struct.
`default_nettype none

package cirp_pkg;

    // ------------------------------------------------------------------
    // Decoded access target
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ACC_NONE  = 3'h0,
        ACC_LOW   = 3'h1,
        ACC_HIGH  = 3'h2,
        ACC_INDEX = 3'h3,
        ACC_CTRL  = 3'h4,
        ACC_TEST  = 3'h5,
        ACC_STAT  = 3'h6
    } cirp_acc_t;

    // ------------------------------------------------------------------
    // Module state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  high;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        irq_flag;
        logic        we;
        logic [7:0]  waddr;
        logic [15:0] wdata;
        logic [1:0]  wbe;
    } cirp_top_t;

    typedef struct packed {
        logic [7:0] ptr;
    } cirp_ptr_t;

endpackage

`default_nettype wire

// *** hw/cirp_ptr_if.sv ***
// Purpose: Carrier between the window decode and the index pointer.
// Assumes: Single clock domain.
// Notes:   load and inc are one-cycle pulses.
`default_nettype none

interface cirp_ptr_if;
    logic       load;
    logic [7:0] load_val;
    logic       inc;
    logic [7:0] ptr;

    modport owner (
        input  load,
        input  load_val,
        input  inc,
        output ptr
    );

    modport user (
        output load,
        output load_val,
        output inc,
        input  ptr
    );
endinterface

`default_nettype wire

// *** hw/cirp_top.sv ***
// Purpose: Special-function window onto the registers of an embedded CAN controller.
// Assumes: One access per cycle; sfr_rd and sfr_wr never together.
// Notes:   Controller reads are combinational on ctl_raddr; writes leave registered.
`include "cirp_defines.svh"
`default_nettype none

// Operation
// - index pointer selects register for data pair
// - pointer advances after low write in ranges
// - low data byte at 0xD8, resets 0x01
// - index pointer at 0xDA, resets zero
// - interrupt flag is read-only control bit four
// - flag clears only when controller interrupts clear
// - control register directly at 0xF8
// - direct and indexed paths reach same register
// - status register directly at 0xC0
module cirp_top
    import cirp_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_page,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    output logic             sfr_rvalid,
    output logic      [7:0]  ctl_raddr,
    input  wire logic [15:0] ctl_rdata,
    output logic             ctl_we,
    output logic      [7:0]  ctl_waddr,
    output logic      [15:0] ctl_wdata,
    output logic      [1:0]  ctl_wbe,
    input  wire logic        ctl_irq_pending
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam cirp_top_t TOP_RST = '{
        high:     `CIRP_RST_HIGH,
        rdata:    8'h00,
        rvalid:   1'b0,
        irq_flag: 1'b0,
        we:       1'b0,
        waddr:    `CIRP_IDX_CTRL,
        wdata:    `CIRP_RST_WORD,
        wbe:      2'b00
    };

    cirp_top_t  st_q;
    cirp_top_t  st_d;
    cirp_acc_t  acc;
    logic [7:0] sel_idx;
    logic [7:0] rd_low;

    cirp_ptr_if ptr_bus ();

    cirp_index_ptr u_ptr (
        .clock (clock),
        .reset (reset),
        .bus   (ptr_bus)
    );

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Any page other than the window page, or an address not listed,
    // decodes to nothing: writes are dropped and reads return zero.
    always_comb begin
        acc = ACC_NONE;
        if (sfr_page == `CIRP_PAGE) begin
            case (sfr_addr)
                `CIRP_ADDR_LOW:   acc = ACC_LOW;
                `CIRP_ADDR_HIGH:  acc = ACC_HIGH;
                `CIRP_ADDR_INDEX: acc = ACC_INDEX;
                `CIRP_ADDR_CTRL:  acc = ACC_CTRL;
                `CIRP_ADDR_TEST:  acc = ACC_TEST;
                `CIRP_ADDR_STAT:  acc = ACC_STAT;
                default:          acc = ACC_NONE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Controller register selection
    // ------------------------------------------------------------------
    // Direct windows map onto the same controller indexes the pointer
    // would use, so no shadow copy can drift from the controller.
    always_comb begin
        case (acc)
            ACC_CTRL: sel_idx = `CIRP_IDX_CTRL;
            ACC_TEST: sel_idx = `CIRP_IDX_TEST;
            ACC_STAT: sel_idx = `CIRP_IDX_STAT;
            default:  sel_idx = ptr_bus.ptr;
        endcase
    end

    assign ctl_raddr = sel_idx;

    // The flag bit is owned here, not by the controller's stored word.
    always_comb begin
        rd_low = ctl_rdata[7:0];
        if (sel_idx == `CIRP_IDX_CTRL) begin
            rd_low[`CIRP_IRQ_BIT] = st_q.irq_flag;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d        = st_q;
        st_d.rvalid = 1'b0;
        st_d.we     = 1'b0;

        // The flag follows the controller's combined pending level, so it
        // drops only once every source inside the controller is cleared.
        st_d.irq_flag = ctl_irq_pending;

        if (sfr_rd) begin
            st_d.rvalid = 1'b1;
            case (acc)
                ACC_LOW:   st_d.rdata = rd_low;
                ACC_HIGH:  st_d.rdata = ctl_rdata[15:8];
                ACC_INDEX: st_d.rdata = ptr_bus.ptr;
                ACC_CTRL:  st_d.rdata = rd_low;
                ACC_TEST:  st_d.rdata = rd_low;
                ACC_STAT:  st_d.rdata = rd_low;
                default:   st_d.rdata = 8'h00;
            endcase
        end

        if (sfr_wr) begin
            case (acc)
                ACC_HIGH: begin
                    st_d.high = sfr_wdata;
                end
                ACC_LOW: begin
                    st_d.we    = 1'b1;
                    st_d.waddr = ptr_bus.ptr;
                    st_d.wdata = {st_q.high, sfr_wdata};
                    st_d.wbe   = 2'b11;
                end
                ACC_CTRL, ACC_TEST, ACC_STAT: begin
                    st_d.we    = 1'b1;
                    st_d.waddr = sel_idx;
                    st_d.wdata = {8'h00, sfr_wdata};
                    st_d.wbe   = 2'b01;
                end
                default: begin
                    st_d.we = 1'b0;
                end
            endcase
        end

        // Writes to the flag position never reach the controller.
        if (st_d.we && (st_d.waddr == `CIRP_IDX_CTRL)) begin
            st_d.wdata[`CIRP_IRQ_BIT] = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_q <= TOP_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Pointer control
    // ------------------------------------------------------------------
    assign ptr_bus.load     = sfr_wr && (acc == ACC_INDEX);
    assign ptr_bus.load_val = sfr_wdata;
    assign ptr_bus.inc      = sfr_wr && (acc == ACC_LOW);

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign sfr_rdata  = st_q.rdata;
    assign sfr_rvalid = st_q.rvalid;
    assign ctl_we     = st_q.we;
    assign ctl_waddr  = st_q.waddr;
    assign ctl_wdata  = st_q.wdata;
    assign ctl_wbe    = st_q.wbe;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    AST_LOW_READ: assert property (
        (sfr_rd && (acc == ACC_LOW) && (ctl_raddr != `CIRP_IDX_CTRL))
        |=> (sfr_rvalid && (sfr_rdata == $past(ctl_rdata[7:0])))
    ) else $error("low byte read did not return the selected register");

    AST_LOW_COMMIT: assert property (
        (sfr_wr && (acc == ACC_LOW))
        |=> (ctl_we && (ctl_wbe == 2'b11) && (ctl_waddr == $past(ctl_raddr)))
    ) else $error("low byte write did not commit to the pointed register");

    AST_LOW_RESET: assert property (
        @(posedge clock) disable iff (1'b0)
        $fell(reset) |-> ((ctl_wdata == `CIRP_RST_WORD) && !ctl_we && !sfr_rvalid)
    ) else $error("data word not at its reset value");

    AST_INDEX_LOAD: assert property (
        (sfr_wr && (acc == ACC_INDEX))
        ##1 (sfr_rd && (acc == ACC_INDEX))
        |=> (sfr_rdata == $past(sfr_wdata, 2))
    ) else $error("index pointer read back wrong value");

    AST_FLAG_READ: assert property (
        (sfr_rd && (acc == ACC_CTRL))
        |=> (sfr_rdata[`CIRP_IRQ_BIT] == $past(st_q.irq_flag))
    ) else $error("control read did not show the interrupt flag");

    AST_FLAG_NOWRITE: assert property (
        (sfr_wr && (acc == ACC_CTRL)) |=> (ctl_wdata[`CIRP_IRQ_BIT] == 1'b0)
    ) else $error("flag bit written through to the controller");

    AST_FLAG_FOLLOW: assert property (
        ctl_irq_pending |=> st_q.irq_flag
    ) else $error("interrupt flag not raised by a pending interrupt");

    AST_FLAG_CLEAR: assert property (
        !ctl_irq_pending |=> !st_q.irq_flag
    ) else $error("interrupt flag still set with nothing pending");

    AST_CTRL_DIRECT: assert property (
        (sfr_wr && (acc == ACC_CTRL))
        |=> (ctl_we && (ctl_waddr == `CIRP_IDX_CTRL) && (ctl_wbe == 2'b01)
             && (ctl_wdata[7:0] == ($past(sfr_wdata) & 8'hEF)))
    ) else $error("direct control write did not reach index zero");

    AST_SAME_REG: assert property (
        (acc == ACC_TEST) |-> (ctl_raddr == `CIRP_IDX_TEST)
    ) else $error("direct test access selected another register");

    AST_STAT_DIRECT: assert property (
        (sfr_wr && (acc == ACC_STAT))
        |=> (ctl_we && (ctl_waddr == `CIRP_IDX_STAT)
             && (ctl_wdata[7:0] == $past(sfr_wdata)))
    ) else $error("direct status write did not reach index one");

    AST_HIGH_HOLD: assert property (
        (sfr_wr && (acc == ACC_HIGH)) ##1 (!sfr_wr [*2]) ##1 (sfr_wr && (acc == ACC_LOW))
        |=> (ctl_wdata[15:8] == $past(sfr_wdata, 4))
    ) else $error("held high byte lost before the low write");

    AST_HIGH_NOWRITE: assert property (
        (sfr_wr && (acc == ACC_HIGH)) |=> !ctl_we
    ) else $error("high byte write reached the controller early");

    AST_WE_ONLY_ON_WRITE: assert property (
        ctl_we |-> $past(sfr_wr)
    ) else $error("controller write without a window write");

    AST_HIGH_READ: assert property (
        (sfr_rd && (acc == ACC_HIGH))
        |=> (sfr_rvalid && (sfr_rdata == $past(ctl_rdata[15:8])))
    ) else $error("high byte read did not return the selected register");

    AST_RVALID_ONLY: assert property (
        sfr_rvalid |-> $past(sfr_rd)
    ) else $error("read valid raised without a read");

    AST_UNMAPPED_READ: assert property (
        (sfr_rd && (acc == ACC_NONE)) |=> (sfr_rvalid && (sfr_rdata == 8'h00))
    ) else $error("unmapped read returned data");

    AST_UNMAPPED_WRITE: assert property (
        (sfr_wr && (acc == ACC_NONE)) |=> !ctl_we
    ) else $error("unmapped write reached the controller");

    AST_INDEX_READ: assert property (
        (sfr_rd && (acc == ACC_INDEX)) |=> (sfr_rdata == $past(ctl_raddr))
    ) else $error("index read did not return the pointer");

    AST_CTRL_SEL: assert property (
        (acc == ACC_CTRL) |-> (ctl_raddr == `CIRP_IDX_CTRL)
    ) else $error("direct control access selected another register");

    AST_STAT_SEL: assert property (
        (acc == ACC_STAT) |-> (ctl_raddr == `CIRP_IDX_STAT)
    ) else $error("direct status access selected another register");

    AST_TEST_DIRECT: assert property (
        (sfr_wr && (acc == ACC_TEST))
        |=> (ctl_we && (ctl_waddr == `CIRP_IDX_TEST) && (ctl_wbe == 2'b01)
             && (ctl_wdata[7:0] == $past(sfr_wdata)))
    ) else $error("direct test write did not reach index five");

endmodule

`default_nettype wire

// *** verification/cirp_ctl_model.sv ***
// Purpose: Behavioural register array of the embedded CAN controller behind the port.
// Assumes: One clock; writes land on the rising edge while we is high.
// Notes:   Reads are combinational, so the port sees the word in the same cycle.
`default_nettype none

module cirp_ctl_model (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [7:0]  raddr,
    output logic      [15:0] rdata,
    input  wire logic        we,
    input  wire logic [7:0]  waddr,
    input  wire logic [15:0] wdata,
    input  wire logic [1:0]  wbe,
    input  wire logic        irq_req,
    output logic             irq_pending
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] regs [0:255];

    assign rdata       = regs[raddr];
    assign irq_pending = irq_req;

    // Byte enables are honoured one by one, so a direct byte write keeps the high byte.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 256; i++) begin
                regs[i] <= 16'h0000;
            end
            regs[8'h00] <= 16'h0001;
            regs[8'h03] <= 16'h2301;
            regs[8'h08] <= 16'h0001;
            regs[8'h20] <= 16'h0001;
        end else if (we) begin
            if (wbe[1]) begin
                regs[waddr][15:8] <= wdata[15:8];
            end
            if (wbe[0]) begin
                regs[waddr][7:0] <= wdata[7:0];
            end
        end
    end
endmodule

`default_nettype wire

// *** verification/cirp_top_tb.sv ***
// Purpose: Self-checking bench of the CAN register port against a controller model.
// Assumes: Inputs change on the falling edge; the design samples on the rising edge.
// Notes:   Controller contents are checked in the model array as well as by read-back.
`include "cirp_defines.svh"
`default_nettype none

module cirp_top_tb
    import cirp_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock;
    logic        reset;
    logic [7:0]  sfr_addr;
    logic [7:0]  sfr_page;
    logic        sfr_wr;
    logic        sfr_rd;
    logic [7:0]  sfr_wdata;
    logic [7:0]  sfr_rdata;
    logic        sfr_rvalid;
    logic [7:0]  ctl_raddr;
    logic [15:0] ctl_rdata;
    logic        ctl_we;
    logic [7:0]  ctl_waddr;
    logic [15:0] ctl_wdata;
    logic [1:0]  ctl_wbe;
    logic        ctl_irq_pending;
    logic        irq_req;
    logic [7:0]  pg;
    logic [7:0]  d;
    int          errors;
    int          n_tests;
    int          cycles;

    cirp_top i_cirp_top (
        .clock           (clock),
        .reset           (reset),
        .sfr_addr        (sfr_addr),
        .sfr_page        (sfr_page),
        .sfr_wr          (sfr_wr),
        .sfr_rd          (sfr_rd),
        .sfr_wdata       (sfr_wdata),
        .sfr_rdata       (sfr_rdata),
        .sfr_rvalid      (sfr_rvalid),
        .ctl_raddr       (ctl_raddr),
        .ctl_rdata       (ctl_rdata),
        .ctl_we          (ctl_we),
        .ctl_waddr       (ctl_waddr),
        .ctl_wdata       (ctl_wdata),
        .ctl_wbe         (ctl_wbe),
        .ctl_irq_pending (ctl_irq_pending)
    );

    cirp_ctl_model i_cirp_ctl_model (
        .clock       (clock),
        .reset       (reset),
        .raddr       (ctl_raddr),
        .rdata       (ctl_rdata),
        .we          (ctl_we),
        .waddr       (ctl_waddr),
        .wdata       (ctl_wdata),
        .wbe         (ctl_wbe),
        .irq_req     (irq_req),
        .irq_pending (ctl_irq_pending)
    );

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Holds the strobe up so that writes may follow back to back.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clock);
        sfr_rd    = 1'b0;
        sfr_wr    = 1'b1;
        sfr_page  = pg;
        sfr_addr  = a;
        sfr_wdata = v;
        @(posedge clock);
    endtask

    task automatic idle();
        @(negedge clock);
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clock);
        sfr_wr   = 1'b0;
        sfr_rd   = 1'b1;
        sfr_page = pg;
        sfr_addr = a;
        @(posedge clock);
        @(negedge clock);
        sfr_rd = 1'b0;
        check(16'(sfr_rvalid), 16'h0001);
        v = sfr_rdata;
    endtask

    task automatic chk_cw(input logic [7:0] a, input logic [15:0] v, input logic [1:0] be);
        check(16'(ctl_we), 16'h0001);
        check(16'(ctl_waddr), 16'(a));
        check(ctl_wdata, v);
        check(16'(ctl_wbe), 16'(be));
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        check(ctl_wdata, 16'h0001);
        rd(`CIRP_ADDR_INDEX, d);
        check(16'(d), 16'h0000);
        rd(`CIRP_ADDR_LOW, d);
        check(16'(d), 16'h0001);
    endtask

    // Two idle cycles between the byte writes show that the high byte is held.
    task automatic t_pair();
        wr(`CIRP_ADDR_INDEX, 8'h03);
        rd(`CIRP_ADDR_INDEX, d);
        check(16'(d), 16'h0003);
        wr(`CIRP_ADDR_HIGH, 8'h23);
        idle();
        check(16'(ctl_we), 16'h0000);
        idle();
        wr(`CIRP_ADDR_LOW, 8'h04);
        idle();
        chk_cw(8'h03, 16'h2304, 2'b11);
        rd(`CIRP_ADDR_INDEX, d);
        check(16'(d), 16'h0003);
        check(i_cirp_ctl_model.regs[8'h03], 16'h2304);
        rd(`CIRP_ADDR_LOW, d);
        check(16'(d), 16'h0004);
        rd(`CIRP_ADDR_HIGH, d);
        check(16'(d), 16'h0023);
    endtask

    // Range edges on both sides; the held high byte 0x23 is reused by every low write in the edge loop, then 0x5A by the three-write burst.
    task automatic t_autoinc();
        logic [7:0] s [8];
        logic [7:0] e;
        s = '{8'h07, 8'h08, 8'h12, 8'h13, 8'h1F, 8'h20, 8'h2A, 8'h2B};
        foreach (s[i]) begin
            wr(`CIRP_ADDR_INDEX, s[i]);
            wr(`CIRP_ADDR_LOW, s[i]);
            idle();
            rd(`CIRP_ADDR_INDEX, d);
            e = ((s[i] >= 8'h08 && s[i] <= 8'h12) || (s[i] >= 8'h20 && s[i] <= 8'h2A))
                ? s[i] + 8'h01 : s[i];
            check(16'(d), 16'(e));
            check(i_cirp_ctl_model.regs[s[i]], {8'h23, s[i]});
        end
        wr(`CIRP_ADDR_INDEX, 8'h08);
        wr(`CIRP_ADDR_HIGH, 8'h5A);
        for (int i = 1; i <= 3; i++) begin
            wr(`CIRP_ADDR_LOW, 8'(i));
        end
        idle();
        rd(`CIRP_ADDR_INDEX, d);
        check(16'(d), 16'h000B);
        for (int i = 0; i < 3; i++) begin
            check(i_cirp_ctl_model.regs[8'h08 + i], {8'h5A, 8'(i + 1)});
        end
    endtask

    task automatic t_direct();
        wr(`CIRP_ADDR_CTRL, 8'h5A);
        idle();
        chk_cw(8'h00, 16'h004A, 2'b01);
        wr(`CIRP_ADDR_INDEX, 8'h00);
        rd(`CIRP_ADDR_LOW, d);
        check(16'(d), 16'h004A);
        wr(`CIRP_ADDR_TEST, 8'h33);
        idle();
        wr(`CIRP_ADDR_INDEX, 8'h05);
        rd(`CIRP_ADDR_LOW, d);
        check(16'(d), 16'h0033);
        check(i_cirp_ctl_model.regs[8'h05], 16'h0033);
        wr(`CIRP_ADDR_INDEX, 8'h01);
        wr(`CIRP_ADDR_LOW, 8'h77);
        // The controller takes the word one edge after the write pulse.
        idle();
        rd(`CIRP_ADDR_STAT, d);
        check(16'(d), 16'h0077);
        rd(`CIRP_ADDR_CTRL, d);
        check(16'(d), 16'h004A);
    endtask

    task automatic t_irq();
        @(negedge clock);
        irq_req = 1'b1;
        repeat (2) @(negedge clock);
        rd(`CIRP_ADDR_CTRL, d);
        check(16'(d), 16'h005A);
        wr(`CIRP_ADDR_CTRL, 8'h4A);
        idle();
        rd(`CIRP_ADDR_CTRL, d);
        check(16'(d), 16'h005A);
        wr(`CIRP_ADDR_INDEX, 8'h00);
        rd(`CIRP_ADDR_LOW, d);
        check(16'(d), 16'h005A);
        irq_req = 1'b0;
        repeat (2) @(negedge clock);
        wr(`CIRP_ADDR_CTRL, 8'hFF);
        idle();
        rd(`CIRP_ADDR_CTRL, d);
        check(16'(d), 16'h00EF);
    endtask

    task automatic t_unmapped();
        pg = 8'h00;
        wr(`CIRP_ADDR_LOW, 8'h99);
        idle();
        check(16'(ctl_we), 16'h0000);
        pg = `CIRP_PAGE;
        rd(8'h55, d);
        check(16'(d), 16'h0000);
    endtask

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task automatic results();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // The whole run needs just over a hundred cycles; the ceiling leaves ample margin.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            results();
        end
    end

    initial begin
        reset     = 1'b1;
        sfr_addr  = 8'h00;
        sfr_page  = 8'h00;
        sfr_wr    = 1'b0;
        sfr_rd    = 1'b0;
        sfr_wdata = 8'h00;
        irq_req   = 1'b0;
        pg        = `CIRP_PAGE;
        errors    = 0;
        n_tests   = 0;
        cycles    = 0;
        repeat (10) @(negedge clock);
        reset = 1'b0;
        t_reset();
        t_pair();
        t_autoinc();
        t_direct();
        t_irq();
        t_unmapped();
        results();
    end
endmodule

`default_nettype wire
